// ===== verilog/plcb_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Bypass bit set removes slope ramp; resets zero.
// - Six-bit slew code goes straight to ramp.
// - Unimplemented bits read zero, ignore writes.
// - Upper offset nibble is channel 1 code.
// - Lower offset nibble is channel 2 code.
// - Offset is added to primary current sense.
// - Bits 3:2 pick channel 1 blanking time.
// - Bits 1:0 pick channel 2 blanking time.
// - Blanking suppresses current sense at cycle start.
// - Loop clamp bit resets one, grounds nodes.
// - Bit 5 reads in-regulation comparator, read-only.
// - Rise enable sets flag on rising edge.
// - Fall enable sets flag on falling edge.
// - Each channel owns its own flag.
// - Bit 2 reads dominant loop, read-only.
// - Slope ramp adds to error amplifier output.
module plcb_bank (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        ch1_regulation_ok,
  input  wire logic        ch2_regulation_ok,
  input  wire logic        ch1_dominant_loop_is_voltage,
  input  wire logic        ch2_dominant_loop_is_voltage,
  input  wire logic        ch1_cycle_start,
  input  wire logic        ch2_cycle_start,
  output var  logic        ch1_loop_comp_clamp,
  output var  logic        ch2_loop_comp_clamp,
  output var  logic        ch2_ramp_bypass,
  output var  logic        ch2_ramp_enable,
  output var  logic [5:0]  ch2_ramp_slew_code,
  output var  logic [3:0]  ch1_offset_code,
  output var  logic [3:0]  ch2_offset_code,
  output var  logic        ch1_offset_add_en,
  output var  logic        ch2_offset_add_en,
  output var  logic [1:0]  ch1_blanking_code,
  output var  logic [1:0]  ch2_blanking_code,
  output var  logic        ch1_sense_blank,
  output var  logic        ch2_sense_blank,
  output var  logic        ch1_reg_ok_flag,
  output var  logic        ch2_reg_ok_flag
);
  logic       clamp1_r;
  logic       clamp2_r;
  logic       rise1_r;
  logic       fall1_r;
  logic       rise2_r;
  logic       fall2_r;
  logic       bypass_r;
  logic [5:0] slew_r;
  logic [3:0] ofs1_r;
  logic [3:0] ofs2_r;
  logic [1:0] leb1_r;
  logic [1:0] leb2_r;
  logic       flag1_r;
  logic       flag2_r;
  logic       ok1_s;
  logic       ok2_s;
  logic       dom1_s;
  logic       dom2_s;
  logic       ok1_prev_r;
  logic       ok2_prev_r;
  logic       blank1;
  logic       blank2;
  logic       req;
  logic       wr_en;
  logic       wr_b0;
  logic       wr_loop1;
  logic       wr_loop2;
  logic       wr_slope;
  logic       wr_offset;
  logic       wr_blank;
  logic       wr_flags;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rd_nxt;
  logic       ev1;
  logic       ev2;

  // Bring the asynchronous comparator outputs into the clock domain.
  plcb_sync u_sync_ok1 (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (ch1_regulation_ok),
    .sync_out (ok1_s)
  );
  plcb_sync u_sync_ok2 (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (ch2_regulation_ok),
    .sync_out (ok2_s)
  );
  plcb_sync u_sync_dom1 (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (ch1_dominant_loop_is_voltage),
    .sync_out (dom1_s)
  );
  plcb_sync u_sync_dom2 (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (ch2_dominant_loop_is_voltage),
    .sync_out (dom2_s)
  );

  // Leading-edge blanking windows for both channels.
  plcb_blank u_blank1 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .cycle_start (ch1_cycle_start),
    .code        (leb1_r),
    .blank       (blank1)
  );
  plcb_blank u_blank2 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .cycle_start (ch2_cycle_start),
    .code        (leb2_r),
    .blank       (blank2)
  );

  // Bus decode: a write needs the low byte lane; the answer is one cycle late.
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx   = wb_adr_i[9:2];
  assign wr_en = req && wb_we_i;
  assign wr_b0 = wr_en && wb_sel_i[0];
  assign wd    = wb_dat_i[7:0];

  // One write strobe per register, so each register's update tests a single name.
  assign wr_loop1  = wr_b0 && (idx == plcb_pkg::IDX_CH1_LOOP);
  assign wr_loop2  = wr_b0 && (idx == plcb_pkg::IDX_CH2_LOOP);
  assign wr_slope  = wr_b0 && (idx == plcb_pkg::IDX_CH2_SLOPE);
  assign wr_offset = wr_b0 && (idx == plcb_pkg::IDX_OFFSET);
  assign wr_blank  = wr_b0 && (idx == plcb_pkg::IDX_BLANKING);
  assign wr_flags  = wr_b0 && (idx == plcb_pkg::IDX_REG_OK_FLAGS);

  // Acknowledge every request, mapped or not, after one cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Loop control writable bits; reserved and read-only bits are dropped.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clamp1_r <= plcb_pkg::RST_CLAMP;
      clamp2_r <= plcb_pkg::RST_CLAMP;
      rise1_r  <= plcb_pkg::RST_EDGE_EN;
      fall1_r  <= plcb_pkg::RST_EDGE_EN;
      rise2_r  <= plcb_pkg::RST_EDGE_EN;
      fall2_r  <= plcb_pkg::RST_EDGE_EN;
    end else if (wr_loop1) begin
      clamp1_r <= wd[plcb_pkg::LC_CLAMP_BIT];
      rise1_r  <= wd[plcb_pkg::LC_RISE_BIT];
      fall1_r  <= wd[plcb_pkg::LC_FALL_BIT];
    end else if (wr_loop2) begin
      clamp2_r <= wd[plcb_pkg::LC_CLAMP_BIT];
      rise2_r  <= wd[plcb_pkg::LC_RISE_BIT];
      fall2_r  <= wd[plcb_pkg::LC_FALL_BIT];
    end
  end

  // Slope ramp register for channel 2.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bypass_r <= plcb_pkg::RST_BYPASS;
      slew_r   <= plcb_pkg::RST_SLEW;
    end else if (wr_slope) begin
      bypass_r <= wd[plcb_pkg::SLP_BYPASS_BIT];
      slew_r   <= wd[plcb_pkg::SLP_CODE_MSB:0];
    end
  end

  // Current offset and blanking codes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ofs1_r <= plcb_pkg::RST_OFFSET;
      ofs2_r <= plcb_pkg::RST_OFFSET;
      leb1_r <= plcb_pkg::RST_BLANKING;
      leb2_r <= plcb_pkg::RST_BLANKING;
    end else begin
      if (wr_offset) begin
        ofs1_r <= wd[plcb_pkg::OFS_CH1_LSB +: 4];
        ofs2_r <= wd[plcb_pkg::OFS_CH2_LSB +: 4];
      end
      if (wr_blank) begin
        leb1_r <= wd[plcb_pkg::LEB_CH1_LSB +: 2];
        leb2_r <= wd[plcb_pkg::LEB_CH2_LSB +: 2];
      end
    end
  end

  // Edge event from the current and previous synchronised samples.
  function automatic logic edge_event(input logic rise_en, input logic fall_en,
                                      input logic now_s, input logic prev_s);
    edge_event = (rise_en && now_s && !prev_s) || (fall_en && !now_s && prev_s);
  endfunction : edge_event

  // Each channel's event sees only its own comparator and its own enables.
  assign ev1 = edge_event(rise1_r, fall1_r, ok1_s, ok1_prev_r);
  assign ev2 = edge_event(rise2_r, fall2_r, ok2_s, ok2_prev_r);

  // Sticky flags: write one to clear, a new event wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ok1_prev_r <= 1'b0;
      ok2_prev_r <= 1'b0;
      flag1_r    <= 1'b0;
      flag2_r    <= 1'b0;
    end else begin
      ok1_prev_r <= ok1_s;
      ok2_prev_r <= ok2_s;
      if (ev1) begin
        flag1_r <= 1'b1;
      end else if (wr_flags && wd[0]) begin
        flag1_r <= 1'b0;
      end
      if (ev2) begin
        flag2_r <= 1'b1;
      end else if (wr_flags && wd[1]) begin
        flag2_r <= 1'b0;
      end
    end
  end

  // Read multiplexer; unmapped offsets and unused bits read zero.
  always_comb begin
    rd_nxt = 8'h00;
    unique case (idx)
      plcb_pkg::IDX_CH1_LOOP: begin
        rd_nxt[plcb_pkg::LC_CLAMP_BIT] = clamp1_r;
        rd_nxt[plcb_pkg::LC_OK_BIT]    = ok1_s;
        rd_nxt[plcb_pkg::LC_RISE_BIT]  = rise1_r;
        rd_nxt[plcb_pkg::LC_FALL_BIT]  = fall1_r;
        rd_nxt[plcb_pkg::LC_DOM_BIT]   = dom1_s;
      end
      plcb_pkg::IDX_CH2_LOOP: begin
        rd_nxt[plcb_pkg::LC_CLAMP_BIT] = clamp2_r;
        rd_nxt[plcb_pkg::LC_OK_BIT]    = ok2_s;
        rd_nxt[plcb_pkg::LC_RISE_BIT]  = rise2_r;
        rd_nxt[plcb_pkg::LC_FALL_BIT]  = fall2_r;
        rd_nxt[plcb_pkg::LC_DOM_BIT]   = dom2_s;
      end
      plcb_pkg::IDX_CH2_SLOPE: begin
        rd_nxt[plcb_pkg::SLP_BYPASS_BIT]   = bypass_r;
        rd_nxt[plcb_pkg::SLP_CODE_MSB:0]   = slew_r;
      end
      plcb_pkg::IDX_OFFSET: begin
        rd_nxt = {ofs1_r, ofs2_r};
      end
      plcb_pkg::IDX_BLANKING: begin
        rd_nxt = {4'h0, leb1_r, leb2_r};
      end
      plcb_pkg::IDX_REG_OK_FLAGS: begin
        rd_nxt = {6'h00, flag2_r, flag1_r};
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  // Read data are registered and appear with the acknowledge.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_nxt};
    end
  end

  // Loop clamps towards the compensation nodes, and the flags towards software.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch1_loop_comp_clamp <= plcb_pkg::RST_CLAMP;
      ch2_loop_comp_clamp <= plcb_pkg::RST_CLAMP;
      ch1_reg_ok_flag     <= 1'b0;
      ch2_reg_ok_flag     <= 1'b0;
    end else begin
      ch1_loop_comp_clamp <= clamp1_r;
      ch2_loop_comp_clamp <= clamp2_r;
      ch1_reg_ok_flag     <= flag1_r;
      ch2_reg_ok_flag     <= flag2_r;
    end
  end

  // Ramp controls; bypass resets clear, so the ramp is applied out of reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch2_ramp_bypass    <= plcb_pkg::RST_BYPASS;
      ch2_ramp_enable    <= !plcb_pkg::RST_BYPASS;
      ch2_ramp_slew_code <= plcb_pkg::RST_SLEW;
    end else begin
      ch2_ramp_bypass    <= bypass_r;
      ch2_ramp_enable    <= !bypass_r;
      ch2_ramp_slew_code <= slew_r;
    end
  end

  // Offset codes; the offset is added whenever the sense is not blanked.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch1_offset_code   <= plcb_pkg::RST_OFFSET;
      ch2_offset_code   <= plcb_pkg::RST_OFFSET;
      ch1_offset_add_en <= 1'b1;
      ch2_offset_add_en <= 1'b1;
    end else begin
      ch1_offset_code   <= ofs1_r;
      ch2_offset_code   <= ofs2_r;
      ch1_offset_add_en <= !blank1;
      ch2_offset_add_en <= !blank2;
    end
  end

  // Blanking codes towards the analog side, and the blanking window itself.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch1_blanking_code <= plcb_pkg::RST_BLANKING;
      ch2_blanking_code <= plcb_pkg::RST_BLANKING;
      ch1_sense_blank   <= 1'b0;
      ch2_sense_blank   <= 1'b0;
    end else begin
      ch1_blanking_code <= leb1_r;
      ch2_blanking_code <= leb2_r;
      ch1_sense_blank   <= blank1;
      ch2_sense_blank   <= blank2;
    end
  end
endmodule : plcb_bank
`default_nettype wire

// ===== verilog/plcb_pkg.sv
package plcb_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CH1_LOOP     = 8'h99;
  localparam logic [7:0] IDX_CH2_LOOP     = 8'h9a;
  localparam logic [7:0] IDX_CH2_SLOPE    = 8'h9d;
  localparam logic [7:0] IDX_OFFSET       = 8'h9e;
  localparam logic [7:0] IDX_BLANKING     = 8'h9f;
  localparam logic [7:0] IDX_REG_OK_FLAGS = 8'ha0;
  // Slope register fields.
  localparam int SLP_BYPASS_BIT = 6;
  localparam int SLP_CODE_MSB   = 5;
  // Offset register fields.
  localparam int OFS_CH1_LSB = 4;
  localparam int OFS_CH2_LSB = 0;
  // Blanking register fields.
  localparam int LEB_CH1_LSB = 2;
  localparam int LEB_CH2_LSB = 0;
  // Loop control fields.
  localparam int LC_CLAMP_BIT = 7;
  localparam int LC_OK_BIT    = 5;
  localparam int LC_RISE_BIT  = 4;
  localparam int LC_FALL_BIT  = 3;
  localparam int LC_DOM_BIT   = 2;
  // Reset values.
  localparam logic       RST_CLAMP    = 1'b1;
  localparam logic       RST_EDGE_EN  = 1'b0;
  localparam logic       RST_BYPASS   = 1'b0;
  localparam logic [5:0] RST_SLEW     = 6'h00;
  localparam logic [3:0] RST_OFFSET   = 4'h0;
  localparam logic [1:0] RST_BLANKING = 2'h0;
  // Blanking times per code, in ns, and their cycle counts at 100 MHz.
  localparam int CLK_MHZ   = 100;
  localparam int LEB_NS_01 = 50;
  localparam int LEB_NS_10 = 100;
  localparam int LEB_NS_11 = 200;
  localparam int LEB_CYC_01 = (LEB_NS_01 * CLK_MHZ + 999) / 1000;
  localparam int LEB_CYC_10 = (LEB_NS_10 * CLK_MHZ + 999) / 1000;
  localparam int LEB_CYC_11 = (LEB_NS_11 * CLK_MHZ + 999) / 1000;
endpackage : plcb_pkg

// ===== verilog/plcb_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; the output changes once stages two and three agree.
module plcb_sync (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Stage one feeds only stage two.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end
endmodule : plcb_sync
`default_nettype wire

// ===== verilog/plcb_blank.sv
`timescale 1ns/1ns
`default_nettype none
// Leading-edge blanking timer for one channel, started at each cycle start.
module plcb_blank (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       cycle_start,
  input  wire logic [1:0] code,
  output var  logic       blank
);
  logic [4:0] cnt_r;

  // Convert a blanking code to a cycle count.
  function automatic logic [4:0] leb_cycles(input logic [1:0] c);
    unique case (c)
      2'h0: leb_cycles = 5'h00;
      2'h1: leb_cycles = 5'(plcb_pkg::LEB_CYC_01);
      2'h2: leb_cycles = 5'(plcb_pkg::LEB_CYC_10);
      2'h3: leb_cycles = 5'(plcb_pkg::LEB_CYC_11);
    endcase
  endfunction : leb_cycles

  // Count down the blanking window after each cycle start.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= 5'h00;
    end else if (cycle_start) begin
      cnt_r <= leb_cycles(code);
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  assign blank = (cnt_r != 5'h00);
endmodule : plcb_blank
`default_nettype wire

// ===== dv/plcb_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// Comparators and switching-cycle starts of the analog loop, two channels.
module plcb_analog_model #(
  parameter int PERIOD = 40
) (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [1:0] ok_tgt,
  input  wire logic [1:0] dom_tgt,
  output var  logic [1:0] reg_ok,
  output var  logic [1:0] dom,
  output var  logic [1:0] start
);
  int cnt_r = 0;
  initial {reg_ok, dom, start} = 6'h00;
  // Channel 2 starts half a period after channel 1; the count restarts when run rises.
  always @(posedge ref_clk) begin
    cnt_r <= (!run || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    start <= run ? {cnt_r == PERIOD / 2, cnt_r == 0} : 2'h0;
    reg_ok <= ok_tgt;
    dom <= dom_tgt;
  end
endmodule : plcb_analog_model
`default_nettype wire

// ===== dv/plcb_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Watches bus answers, register outputs, blanking length and flags.
module plcb_checker (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ch1_regulation_ok,
  input wire logic        ch1_loop_comp_clamp,
  input wire logic        ch2_ramp_bypass,
  input wire logic        ch2_ramp_enable,
  input wire logic [5:0]  ch2_ramp_slew_code,
  input wire logic [3:0]  ch1_offset_code,
  input wire logic [3:0]  ch2_offset_code,
  input wire logic        ch1_offset_add_en,
  input wire logic [1:0]  ch1_blanking_code,
  input wire logic        ch1_sense_blank,
  input wire logic        ch1_reg_ok_flag
);
  localparam logic [9:0] A_L1 = {plcb_pkg::IDX_CH1_LOOP, 2'h0};
  localparam logic [9:0] A_SL = {plcb_pkg::IDX_CH2_SLOPE, 2'h0};
  localparam logic [9:0] A_OF = {plcb_pkg::IDX_OFFSET, 2'h0};
  localparam logic [9:0] A_BL = {plcb_pkg::IDX_BLANKING, 2'h0};
  localparam logic [9:0] A_FL = {plcb_pkg::IDX_REG_OK_FLAGS, 2'h0};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // A write taken this edge, and a clear of the channel 1 flag.
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire logic clr1 = wr && wb_adr_i == A_FL && wb_dat_i[0];
  logic [4:0] blk_r;
  logic [3:0] chg_r;
  logic       ok_q_r;
  // Length of the current blanking run, and cycles since the comparator moved.
  always_ff @(posedge ref_clk) begin
    ok_q_r <= ch1_regulation_ok;
    blk_r <= ch1_sense_blank ? blk_r + 5'h01 : 5'h00;
    if (srst) chg_r <= 4'hf;
    else chg_r <= (ok_q_r != ch1_regulation_ok) ? 4'h0 : chg_r + {3'h0, chg_r != 4'hf};
  end
  function automatic logic [4:0] leb_len(input logic [1:0] c);
    leb_len = (c == 2'h1) ? 5'(plcb_pkg::LEB_CYC_01) : (c == 2'h2) ?
              5'(plcb_pkg::LEB_CYC_10) : (c == 2'h3) ? 5'(plcb_pkg::LEB_CYC_11) : 5'h00;
  endfunction : leb_len
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not a single pulse.");
  rd_upper_a: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:8] == 24'h0)
    else $error("Upper read data not zero.");
  clamp_write_a: assert property (wr && wb_adr_i == A_L1 |-> ##2
    ch1_loop_comp_clamp == $past(wb_dat_i[7], 2)) else $error("Clamp output wrong.");
  slope_write_a: assert property (wr && wb_adr_i == A_SL |-> ##2
    {ch2_ramp_bypass, ch2_ramp_slew_code} == $past(wb_dat_i[6:0], 2)) else $error("Slope bad.");
  offset_write_a: assert property (wr && wb_adr_i == A_OF |-> ##2
    {ch1_offset_code, ch2_offset_code} == $past(wb_dat_i[7:0], 2)) else $error("Offset bad.");
  blank_code_a: assert property (wr && wb_adr_i == A_BL |-> ##2
    ch1_blanking_code == $past(wb_dat_i[3:2], 2)) else $error("Blanking code bad.");
  ramp_enable_a: assert property (ch2_ramp_enable != ch2_ramp_bypass)
    else $error("Ramp enable not inverse of bypass.");
  sense_gate_a: assert property (ch1_offset_add_en != ch1_sense_blank)
    else $error("Offset add not gated by blanking.");
  blank_len_a: assert property ($fell(ch1_sense_blank) |-> blk_r == leb_len(ch1_blanking_code))
    else $error("Blanking length wrong.");
  flag_cause_a: assert property ($rose(ch1_reg_ok_flag) |-> chg_r <= 4'h8)
    else $error("Flag rose without comparator edge.");
  flag_hold_a: assert property ($fell(ch1_reg_ok_flag) |-> $past(clr1, 2) || $past(srst))
    else $error("Flag fell without clear.");
  cover property (wr && wb_adr_i == A_L1 && !wb_dat_i[7]);
  cover property ($fell(ch1_sense_blank) && ch1_blanking_code == 2'h3);
  cover property ($rose(ch1_reg_ok_flag));
endmodule : plcb_checker
bind plcb_bank plcb_checker u_chk (.*);
`default_nettype wire

// ===== dv/plcb_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module plcb_bank_test;
  logic        ref_clk, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, ack;
  logic [9:0]  adr = 10'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [1:0]  ok_tgt = 2'h0, dom_tgt = 2'h0, ok, dom, st, clamp, oen, blk, flg;
  logic [1:0]  leb1, leb2;
  logic [5:0]  slew;
  logic [3:0]  ofs1, ofs2;
  logic        byp, ren;
  int          n_errors = 0, cmp_count = 0, seed = 48;
  logic [9:0]  adrs [6];
  logic [7:0]  last [6];
  plcb_analog_model #(.PERIOD(40)) u_model (.ref_clk(ref_clk), .run(run), .ok_tgt(ok_tgt),
    .dom_tgt(dom_tgt), .reg_ok(ok), .dom(dom), .start(st));
  plcb_bank dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ch1_regulation_ok(ok[0]), .ch2_regulation_ok(ok[1]), .ch1_dominant_loop_is_voltage(dom[0]),
    .ch2_dominant_loop_is_voltage(dom[1]), .ch1_cycle_start(st[0]), .ch2_cycle_start(st[1]),
    .ch1_loop_comp_clamp(clamp[0]), .ch2_loop_comp_clamp(clamp[1]), .ch2_ramp_bypass(byp),
    .ch2_ramp_enable(ren), .ch2_ramp_slew_code(slew), .ch1_offset_code(ofs1),
    .ch2_offset_code(ofs2), .ch1_offset_add_en(oen[0]), .ch2_offset_add_en(oen[1]),
    .ch1_blanking_code(leb1), .ch2_blanking_code(leb2), .ch1_sense_blank(blk[0]),
    .ch2_sense_blank(blk[1]), .ch1_reg_ok_flag(flg[0]), .ch2_reg_ok_flag(flg[1]));
  // The clock toggles every 5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // One classic cycle; read data is taken at the edge that sees the answer.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] q);
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, s, 24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb} <= 2'h0;
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, 4'h1, q);
  endtask : wr
  function automatic logic [7:0] exp_rd(input int k, input logic [7:0] d);
    case (k)
      0, 1:    exp_rd = (d & 8'h98) | {2'h0, ok_tgt[k], 2'h0, dom_tgt[k], 2'h0};
      2:       exp_rd = d & 8'h7f;
      3:       exp_rd = d;
      4:       exp_rd = d & 8'h0f;
      default: exp_rd = 8'h00;
    endcase
  endfunction : exp_rd
  function automatic int leb_exp(input int c);
    leb_exp = (c == 1) ? plcb_pkg::LEB_CYC_01 : (c == 2) ? plcb_pkg::LEB_CYC_10 :
              (c == 3) ? plcb_pkg::LEB_CYC_11 : 0;
  endfunction : leb_exp
  // Watchdog for a hung run.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
  // Main sequence: reset values, random register traffic, blanking, flags.
  initial begin : main
    logic [7:0] q, d;
    int         i, k, n, m;
    adrs = '{10'h264, 10'h268, 10'h274, 10'h278, 10'h27c, 10'h3fc};
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    check("clamps", clamp, 2'h3);
    check("reset outs", {ren, byp, oen}, 4'hb);
    for (k = 0; k < 6; k++) begin
      xfer(1'b0, adrs[k], 8'h0, 4'h1, q);
      check("reset read", q, (k < 2) ? 8'h80 : 8'h00);
    end
    $display("reset test done");
    for (i = 0; i < 30; i++) begin
      k = i % 6;
      d = 8'($random(seed));
      ok_tgt <= 2'($random(seed));
      dom_tgt <= 2'($random(seed));
      wr(adrs[k], d);
      last[k] = d;
      repeat (8) @(posedge ref_clk);
      xfer(1'b0, adrs[k], 8'h0, 4'h1, q);
      check("readback", q, exp_rd(k, d));
    end
    xfer(1'b1, adrs[2], ~last[2], 4'h0, q);
    xfer(1'b0, adrs[2], 8'h0, 4'h1, q);
    check("sel0 ignored", q, last[2] & 8'h7f);
    check("clamp out", clamp, {last[1][7], last[0][7]});
    check("slope out", {ren, byp, slew}, {~last[2][6], last[2][6:0]});
    check("offset out", {ofs1, ofs2}, last[3]);
    check("blank out", {leb1, leb2}, last[4][3:0]);
    $display("register test done");
    for (k = 0; k < 4; k++) begin
      run <= 1'b0;
      repeat (25) @(posedge ref_clk);
      wr(adrs[4], {4'h0, 2'(k), 2'(k)});
      run <= 1'b1;
      n = 0;
      m = 0;
      for (i = 0; i < 60 && st[1] !== 1'b1; i++) @(posedge ref_clk);
      for (i = 0; i < 30; i++) begin
        @(posedge ref_clk);
        n += (blk[1] === 1'b1) ? 1 : 0;
        m += (oen[1] === blk[1]) ? 1 : 0;
      end
      check("blank len", n, leb_exp(k));
      check("add en", m, 0);
    end
    $display("blanking test done");
    run <= 1'b0;
    ok_tgt <= 2'h0;
    repeat (8) @(posedge ref_clk);
    wr(adrs[0], 8'h10);
    wr(adrs[1], 8'h08);
    wr(10'h280, 8'h03);
    repeat (4) @(posedge ref_clk);
    check("flags clear", {clamp, flg}, 4'h0);
    ok_tgt <= 2'h3;
    repeat (10) @(posedge ref_clk);
    check("rise flags", flg, 2'h1);
    ok_tgt <= 2'h0;
    repeat (10) @(posedge ref_clk);
    check("fall flags", flg, 2'h3);
    xfer(1'b0, 10'h280, 8'h0, 4'h1, q);
    check("flag reg", q, 8'h03);
    wr(10'h280, 8'h01);
    repeat (3) @(posedge ref_clk);
    check("one cleared", flg, 2'h2);
    $display("flag test done");
    stop_test();
  end
endmodule : plcb_bank_test
`default_nettype wire
